// ### logic/acr_pkg.sv
package acr_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RESULT_HIGH    = 4'h4;
  localparam logic [3:0] ADDR_RESULT_LOW     = 4'h8;
  localparam logic [3:0] ADDR_PIN_ENABLE     = 4'hc;
  localparam logic [4:0] ADDR_CONTROL_W      = 5'h10;
  // Status and control fields
  localparam int DONE_BIT      = 7;
  localparam int IRQ_EN_BIT    = 6;
  localparam int CONT_BIT      = 5;
  localparam int CHAN_MSB      = 4;
  // Converter control fields
  localparam int EIGHT_BIT_RESOLUTION_BIT      = 6;
  localparam int JUSTIFY_BIT   = 5;
  localparam int SIGNED_BIT    = 4;
  localparam int PRESCALE_MSB  = 3;
  // Channel codes
  localparam logic [4:0] CHAN_LAST_PIN = 5'h07;
  localparam logic [4:0] CHAN_HIGH_REF = 5'h1e;
  localparam logic [4:0] CHAN_LOW_REF  = 5'h1f;
  // Reset values
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h1f;
  localparam logic [7:0] RST_PIN_ENABLE     = 8'h00;
  localparam logic [7:0] RST_CONV_CONTROL   = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Prescale factor = (field + 1) * 2
  function automatic logic [5:0] prescale_factor(input logic [3:0] f);
    return {1'b0, ({1'b0, f} + 5'h01)} << 1;
  endfunction
endpackage

// ### logic/acr_prescaler.sv
`timescale 1ns/100ps
module acr_prescaler
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       run,
  input  wire logic [3:0] conv_clock_prescale,
  // Conversion clock enable
  output logic            conv_tick
);
  logic [5:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r     <= 6'h00;
      conv_tick <= 1'b0;
    end else if (cnt_r + 6'h01 >= prescale_factor(conv_clock_prescale)) begin
      cnt_r     <= 6'h00;
      conv_tick <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 6'h01;
      conv_tick <= 1'b0;
    end
  end

  prescale_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(conv_tick) && run |-> ##1 !conv_tick)
    else $error("conversion tick longer than one cycle");
endmodule // acr_prescaler

// ### logic/acr_adc_ctrl.sv
`timescale 1ns/100ps
// How it works
// - Any status/control write clears done flag, drops interrupt, starts fresh conversion
// - Done flag at bit 7, read-only, set by hardware on each completion that no status/control or pin-enable write meets in the same cycle
// - Reading high or low result register clears done flag
// - With enable bit 6 set, interrupt follows done flag
// - Reset clears pending interrupt; without enable software polls the flag
// - Continuous bit 5 converts back to back; else one per write
// - Channel codes 00-07 pins, 1E high reference, others low reference
// - Left justified: result 9:2 to high 7:0, 1:0 to low 7:6
// - Right justified: result 9:8 to high 1:0, 7:0 to low
// - Justify bit in converter control register selects packing
// - Eight-bit result sits in high register; low reads zero
// - Unused result bits read zero
// - Result registers are read-only; writes change nothing
// - Pin-enable write aborts conversion and starts none
// - Disabled pin converts low reference, results zero
// - One enable bit per pin, 1 enables
// - Prescale factor is (field + 1) times 2
// - Signed inverts result MSB only while the justify bit is clear, in either resolution
// - Eight-bit mode is always left justified
module acr_adc_ctrl
  import acr_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Analog core
  output logic             core_start,
  output logic [4:0]       core_channel,
  output logic             core_abort,
  output logic             conv_tick,
  output logic             eight_bit_resolution,
  input  wire logic        core_done,
  input  wire logic [9:0]  core_result,
  // Interrupt request
  output logic             conv_irq
);
  typedef enum logic [1:0] {ACR_IDLE, ACR_START, ACR_BUSY} acr_state_t;

  acr_state_t  state_r;
  logic        conv_done_flag_r;
  logic        conv_irq_enable_r;
  logic        continuous_convert_r;
  logic [4:0]  channel_select_r;
  logic [7:0]  analog_pin_enable_r;
  logic [7:0]  conv_control_r;
  logic [7:0]  result_high_r;
  logic [7:0]  result_low_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [4:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  logic        sc_write;
  logic        pe_write;
  logic        rd_fire;
  logic        res_read;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic        wr_hit;
  logic        justify_select;
  logic        signed_result_select;
  logic [3:0]  conv_clock_prescale;
  logic [7:0]  high_nxt;
  logic [7:0]  low_nxt;
  logic [9:0]  value;

  assign eight_bit_resolution = conv_control_r[EIGHT_BIT_RESOLUTION_BIT];
  assign justify_select       = conv_control_r[JUSTIFY_BIT];
  assign signed_result_select = conv_control_r[SIGNED_BIT];
  assign conv_clock_prescale  = conv_control_r[PRESCALE_MSB:0];

  // Channel decode, also forces disabled pins to the low reference
  function automatic logic [4:0] route_channel(input logic [4:0] sel, input logic [7:0] pe);
    if (sel <= CHAN_LAST_PIN)
      return pe[sel[2:0]] ? sel : CHAN_LOW_REF;
    else if (sel == CHAN_HIGH_REF)
      return CHAN_HIGH_REF;
    else
      return CHAN_LOW_REF;
  endfunction

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 5'h00;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  assign wr_fire  = aw_held_r && w_held_r;
  assign wr_hit   = aw_addr_r == {1'b0, ADDR_STATUS_CONTROL} || aw_addr_r == {1'b0, ADDR_PIN_ENABLE} ||
                    aw_addr_r == ADDR_CONTROL_W || aw_addr_r == {1'b0, ADDR_RESULT_HIGH} ||
                    aw_addr_r == {1'b0, ADDR_RESULT_LOW};
  assign sc_write = wr_fire && aw_addr_r == {1'b0, ADDR_STATUS_CONTROL} && w_strb_r[0];
  assign pe_write = wr_fire && aw_addr_r == {1'b0, ADDR_PIN_ENABLE} && w_strb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; result registers ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_irq_enable_r    <= RST_STATUS_CONTROL[IRQ_EN_BIT];
      continuous_convert_r <= RST_STATUS_CONTROL[CONT_BIT];
      channel_select_r     <= RST_STATUS_CONTROL[CHAN_MSB:0];
    end else if (sc_write) begin
      conv_irq_enable_r    <= w_data_r[IRQ_EN_BIT];
      continuous_convert_r <= w_data_r[CONT_BIT];
      channel_select_r     <= w_data_r[CHAN_MSB:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_pin_enable_r <= RST_PIN_ENABLE;
      conv_control_r      <= RST_CONV_CONTROL;
    end else if (wr_fire && w_strb_r[0]) begin
      if (aw_addr_r == {1'b0, ADDR_PIN_ENABLE})
        analog_pin_enable_r <= w_data_r[7:0];
      if (aw_addr_r == ADDR_CONTROL_W)
        conv_control_r <= w_data_r[7:0];
    end
  end

  // Read channel, one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign res_read      = rd_fire && (s_axi_araddr == {1'b0, ADDR_RESULT_HIGH} ||
                                     s_axi_araddr == {1'b0, ADDR_RESULT_LOW});

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      {1'b0, ADDR_STATUS_CONTROL}: rd_val = {conv_done_flag_r, conv_irq_enable_r, continuous_convert_r,
                                            channel_select_r};
      {1'b0, ADDR_RESULT_HIGH}:    rd_val = result_high_r;
      {1'b0, ADDR_RESULT_LOW}:     rd_val = result_low_r;
      {1'b0, ADDR_PIN_ENABLE}:     rd_val = analog_pin_enable_r;
      ADDR_CONTROL_W:              rd_val = conv_control_r;
      default:                     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_val};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ACR_IDLE;
    end else if (pe_write) begin
      state_r <= ACR_IDLE;
    end else if (sc_write) begin
      state_r <= ACR_START;
    end else begin
      case (state_r)
        ACR_START: state_r <= ACR_BUSY;
        ACR_BUSY:  if (core_done) state_r <= continuous_convert_r ? ACR_START : ACR_IDLE;
        default:   state_r <= ACR_IDLE;
      endcase
    end
  end

  assign core_start   = state_r == ACR_START;
  assign core_abort   = pe_write || (sc_write && state_r != ACR_IDLE);
  assign core_channel = route_channel(channel_select_r, analog_pin_enable_r);

  acr_prescaler u_prescaler (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .run                 (state_r != ACR_IDLE),
    .conv_clock_prescale (conv_clock_prescale),
    .conv_tick           (conv_tick)
  );

  // Result packing; a forced low reference yields zero from the core
  always_comb begin
    value = core_result;
    if (eight_bit_resolution) begin
      high_nxt = core_result[9:2];
      if (signed_result_select && !justify_select)
        high_nxt[7] = ~high_nxt[7];
      low_nxt  = 8'h00;
    end else if (justify_select) begin
      high_nxt = {6'h00, value[9:8]};
      low_nxt  = value[7:0];
    end else begin
      if (signed_result_select)
        value[9] = ~value[9];
      high_nxt = value[9:2];
      low_nxt  = {value[1:0], 6'h00};
    end
  end

  // A status/control or pin-enable write in the same cycle wins; the finished result belonged to the old setup
  wire capture = state_r == ACR_BUSY && core_done && !pe_write && !sc_write;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_high_r <= 8'h00;
      result_low_r  <= 8'h00;
    end else if (capture) begin
      result_high_r <= high_nxt;
      result_low_r  <= low_nxt;
    end
  end

  // Set wins over a result-read clear; a control write always clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_done_flag_r <= 1'b0;
    end else if (sc_write || pe_write) begin
      conv_done_flag_r <= 1'b0;
    end else if (capture) begin
      conv_done_flag_r <= 1'b1;
    end else if (res_read) begin
      conv_done_flag_r <= 1'b0;
    end
  end

  assign conv_irq = conv_done_flag_r && conv_irq_enable_r;

  done_on_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture |=> conv_done_flag_r && result_high_r == $past(high_nxt))
    else $error("done flag or result not updated on completion");
  write_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sc_write |=> !conv_done_flag_r && !conv_irq && core_start)
    else $error("status write did not clear and restart");
  read_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    res_read && !capture |=> !conv_done_flag_r)
    else $error("result read did not clear done flag");
  irq_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && conv_irq_enable_r |=> conv_irq)
    else $error("interrupt not raised on completion");
  single_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && !continuous_convert_r |=> state_r == ACR_IDLE)
    else $error("single mode kept converting");
  pe_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pe_write |=> state_r == ACR_IDLE ##1 !core_start)
    else $error("pin enable write started a conversion");
  disabled_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_start && channel_select_r <= CHAN_LAST_PIN && !analog_pin_enable_r[channel_select_r[2:0]]
    |-> core_channel == CHAN_LOW_REF)
    else $error("disabled pin not forced to low reference");
  low_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && eight_bit_resolution |=> result_low_r == 8'h00)
    else $error("eight-bit low result not zero");
  start_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_start && !sc_write |=> !core_start)
    else $error("start pulse longer than one cycle");
  irq_reset_a: assert property (@(posedge aclk)
    !aresetn |=> !conv_irq)
    else $error("interrupt pending after reset");
  left_pack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && !eight_bit_resolution && !justify_select |=>
    {result_high_r[6:0], result_low_r} == {$past(core_result[8:0]), 6'h00})
    else $error("left-justified packing wrong");
  right_pack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && !eight_bit_resolution && justify_select |=>
    {result_high_r, result_low_r} == {6'h00, $past(core_result)})
    else $error("right-justified packing wrong");
  eight_bit_pack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && eight_bit_resolution |=> result_high_r[6:0] == $past(core_result[8:2]))
    else $error("eight-bit result not left justified");
  signed_left_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && !justify_select |=>
    result_high_r[7] == ($past(core_result[9]) ^ $past(signed_result_select)))
    else $error("signed left result has wrong top bit");
  result_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && (aw_addr_r == {1'b0, ADDR_RESULT_HIGH} || aw_addr_r == {1'b0, ADDR_RESULT_LOW}) && !capture
    |=> $stable(result_high_r) && $stable(result_low_r))
    else $error("write changed a result register");
  cont_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
    capture && continuous_convert_r |=> core_start)
    else $error("continuous mode did not restart");
endmodule // acr_adc_ctrl

// ### sim/acr_core_model.sv
`timescale 1ns/100ps
module acr_core_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control from the block
  input  wire logic       core_start,
  input  wire logic [4:0] core_channel,
  input  wire logic       core_abort,
  input  wire logic       conv_tick,
  input  wire logic       slow,
  // Answer
  output logic            core_done,
  output logic [9:0]      core_result
);
  logic       busy_r;
  logic [5:0] cnt_r;
  logic [4:0] ch_r;
  function automatic logic [9:0] conv_val(input logic [4:0] ch);
    if (ch <= 5'h07) return 10'h2c5 ^ {7'h0, ch[2:0]};
    if (ch == 5'h1e) return 10'h3ff;
    return 10'h000;
  endfunction
  always_ff @(posedge aclk) begin
    core_done <= 1'b0;
    if (!aresetn) begin
      busy_r      <= 1'b0;
      cnt_r       <= 6'h00;
      core_result <= 10'h155;
    end else if (core_abort) begin
      busy_r <= 1'b0;
    end else if (core_start) begin
      busy_r <= 1'b1;
      cnt_r  <= 6'h00;
      ch_r   <= core_channel;
    end else if (busy_r && conv_tick) begin
      // Slow mode leaves a wide window for an abort
      if (cnt_r == (slow ? 6'h0f : 6'h03)) begin
        busy_r      <= 1'b0;
        core_done   <= 1'b1;
        core_result <= conv_val(ch_r);
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end else begin
      // Result is only valid with the done pulse
      core_result <= ~core_result;
    end
  end
endmodule // acr_core_model

// ### sim/adc_control_and_result_regs_tb.sv
`timescale 1ns/100ps
module adc_control_and_result_regs_tb;
  import acr_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        core_start, core_abort, conv_tick, eight_bit_resolution, core_done, conv_irq;
  logic [4:0]  core_channel;
  logic [9:0]  core_result, pv;
  logic [31:0] rd;
  int          fail_count = 0, n_checks = 0, cyc = 0, aborts = 0;
  // Prescale 6 divides by 14: about 1.8 MHz conversion clock from 25 MHz
  logic [7:0]  t_cc [8] = '{8'h46, 8'h56, 8'h16, 8'h36, 8'h76, 8'h06, 8'h06, 8'h06};
  logic [4:0]  t_ch [8] = '{5'h1e, 5'h1e, 5'h1e, 5'h1e, 5'h1e, 5'h08, 5'h05, 5'h1f};
  logic [15:0] t_hl [8] = '{16'hff00, 16'h7f00, 16'h7fc0, 16'h03ff, 16'hff00, 16'h0, 16'h0, 16'h0};

  acr_adc_ctrl dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .core_start, .core_channel, .core_abort, .conv_tick, .eight_bit_resolution,
    .core_done, .core_result, .conv_irq);
  acr_core_model core (.aclk, .aresetn, .core_start, .core_channel, .core_abort, .conv_tick,
    .slow, .core_done, .core_result);

  always #20 aclk = ~aclk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (core_abort === 1'b1) aborts++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready is sampled at the falling edge; inputs only move at rising edges
  task automatic w(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw, wd, fin;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    fin = 1'b0; n = 0;
    while (!fin && n < 100) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready; wd = s_axi_wvalid & s_axi_wready; fin = s_axi_bvalid;
      if (fin) chk("bresp", er, s_axi_bresp);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (fin) s_axi_bready <= 1'b0;
      n++;
    end
    if (!fin) chk("write answer", 1, 0);
  endtask
  task automatic r(input logic [4:0] a, input logic [1:0] er = RESP_OKAY);
    logic ar, fin;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    fin = 1'b0; n = 0;
    while (!fin && n < 100) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready; fin = s_axi_rvalid; rd = s_axi_rdata;
      if (fin) chk("rresp", er, s_axi_rresp);
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (fin) s_axi_rready <= 1'b0;
      n++;
    end
    if (!fin) chk("read answer", 1, 0);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    r(a);
    chk(nm, {24'h0, e}, rd);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      r(ADDR_STATUS_CONTROL);
      n++;
    end while (rd[7] !== 1'b1 && n < 200);
    chk("done flag", 1, rd[7]);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  initial begin
    idle(10);
    aresetn <= 1'b1;
    rchk("status reset", ADDR_STATUS_CONTROL, RST_STATUS_CONTROL);
    rchk("pin enable reset", ADDR_PIN_ENABLE, RST_PIN_ENABLE);
    rchk("control reset", ADDR_CONTROL_W, RST_CONV_CONTROL);
    $display("test reset done");
    pv = 10'h2c5 ^ 10'h003;
    w(ADDR_CONTROL_W, 8'h06);
    w(ADDR_PIN_ENABLE, 8'h08);
    w(ADDR_STATUS_CONTROL, 8'h43);
    for (int i = 0; i < 200 && conv_irq !== 1'b1; i++) idle(1);
    chk("irq raised", 1, conv_irq);
    rchk("status done", ADDR_STATUS_CONTROL, 8'hc3);
    rchk("left high", ADDR_RESULT_HIGH, pv[9:2]);
    rchk("left low", ADDR_RESULT_LOW, {pv[1:0], 6'h0});
    chk("irq after read", 0, conv_irq);
    idle(150);
    rchk("single mode", ADDR_STATUS_CONTROL, 8'h43);
    $display("test left justified done");
    w(ADDR_CONTROL_W, 8'h26);
    w(ADDR_STATUS_CONTROL, 8'h03);
    wait_done();
    rchk("right high", ADDR_RESULT_HIGH, {6'h0, pv[9:8]});
    rchk("right low", ADDR_RESULT_LOW, pv[7:0]);
    $display("test right justified done");
    for (int i = 0; i < 8; i++) begin
      w(ADDR_CONTROL_W, t_cc[i]);
      w(ADDR_STATUS_CONTROL, {3'h0, t_ch[i]});
      wait_done();
      chk("eight_bit_resolution output", t_cc[i][EIGHT_BIT_RESOLUTION_BIT], eight_bit_resolution);
      rchk("format high", ADDR_RESULT_HIGH, t_hl[i][15:8]);
      rchk("format low", ADDR_RESULT_LOW, t_hl[i][7:0]);
    end
    $display("test formats done");
    w(ADDR_RESULT_HIGH, 8'haa);
    rchk("result kept", ADDR_RESULT_HIGH, 8'h00);
    w(5'h14, 8'h55, RESP_SLVERR);
    r(5'h14, RESP_SLVERR);
    $display("test access done");
    slow <= 1'b1;
    w(ADDR_STATUS_CONTROL, 8'h03);
    idle(10);
    w(ADDR_PIN_ENABLE, 8'h08);
    idle(300);
    rchk("aborted", ADDR_STATUS_CONTROL, 8'h03);
    chk("abort pulses", 2, aborts);
    $display("test abort done");
    slow <= 1'b0;
    w(ADDR_STATUS_CONTROL, 8'h63);
    wait_done();
    rchk("cont result", ADDR_RESULT_HIGH, pv[9:2]);
    wait_done();
    slow <= 1'b1;
    w(ADDR_STATUS_CONTROL, 8'h43);
    chk("irq dropped", 0, conv_irq);
    rchk("write clears", ADDR_STATUS_CONTROL, 8'h43);
    $display("test continuous done");
    wait_done();
    chk("irq pending", 1, conv_irq);
    aresetn <= 1'b0;
    idle(2);
    chk("irq reset", 0, conv_irq);
    aresetn <= 1'b1;
    rchk("status after reset", ADDR_STATUS_CONTROL, RST_STATUS_CONTROL);
    $display("test reset clears irq done");
    report_and_stop();
  end
endmodule // adc_control_and_result_regs_tb
